// ---- hw/fmt_pkg.sv ----
// constants, formats and states shared by the format converter and its register stack
// assumes a single 125 MHz clock domain and an active-low asynchronous reset
package fmt_pkg;
  localparam int EXT_W = 80;
  localparam int ADDR_W = 32;
  localparam int STACK_DEPTH = 8;
  localparam int BCD_DIGITS = 18;
  localparam int BCD_W = 72;
  localparam int DABBLE_STEPS = 64;
  // exponent biases for normalized values
  localparam logic [14:0] BIAS_SHORT = 15'h007f;
  localparam logic [14:0] BIAS_LONG = 15'h03ff;
  localparam logic [14:0] BIAS_EXT = 15'h3fff;
  localparam logic [14:0] EXP_EXT_MAX = 15'h7fff;
  localparam logic [16:0] SHORT_EXP_MAX = 17'h0_00ff;
  localparam logic [16:0] LONG_EXP_MAX = 17'h0_07ff;
  // field positions
  localparam int SIGN_EXT = 79;
  localparam int SIGN_BCD = 79;
  localparam int SIGN_LONG = 63;
  localparam int SIGN_SHORT = 31;
  localparam int WIDTH_I16 = 16;
  localparam int WIDTH_I32 = 32;
  localparam int WIDTH_I64 = 64;
  localparam logic [63:0] BCD_LIMIT = 64'h0de0_b6b3_a764_0000;
  localparam logic [63:0] INT_INDEFINITE = 64'h8000_0000_0000_0000;
  localparam logic [5:0] BCD_STEPS_INIT = 6'h12;
  localparam logic [6:0] DABBLE_INIT = 7'h40;
  localparam logic [2:0] TOP_RESET = 3'h0;
  typedef enum logic [2:0] {FMT_I16, FMT_I32, FMT_I64, FMT_R32, FMT_R64, FMT_BCD, FMT_EXT} fmt_e;
  typedef enum logic [1:0] {ST_IDLE, ST_BCD_LOAD, ST_BCD_STORE, ST_DONE} conv_state_e;
endpackage

// ---- hw/stack_if.sv ----
// carrier between the converter and its eight-entry register stack
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface stack_if;
  logic wr_en;
  logic push;
  logic pop;
  logic [2:0] rel;
  logic [79:0] wr_data;
  logic [79:0] rd_data;
  logic [2:0] top;
  modport owner (output wr_en, output push, output pop, output rel, output wr_data,
    input rd_data, input top);
  modport store (input wr_en, input push, input pop, input rel, input wr_data,
    output rd_data, output top);
endinterface
`default_nettype wire

// ---- hw/reg_stack.sv ----
// eight 80-bit data registers addressed relative to the top-of-stack pointer
// assumes the owner never pushes and pops in the same cycle
`timescale 1ns/100ps
`default_nettype none
module reg_stack (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  stack_if.store bus
);
  import fmt_pkg::*;

  typedef struct packed {
    logic [2:0] top;
    logic [STACK_DEPTH-1:0][EXT_W-1:0] regs;
  } stack_s;

  stack_s cur;
  stack_s next_cur;
  logic [2:0] wr_idx;

  ////////////////////////////////////////////////////////////////////////////
  // the stack grows down: a push moves top one entry lower first
  always_comb begin
    next_cur = cur;
    wr_idx = bus.push ? cur.top - 3'h1 : cur.top + bus.rel;
    if (bus.wr_en) begin
      next_cur.regs[wr_idx] = bus.wr_data;
    end
    if (bus.push) begin
      next_cur.top = cur.top - 3'h1;
    end else if (bus.pop) begin
      next_cur.top = cur.top + 3'h1;
    end
  end

  assign bus.rd_data = cur.regs[cur.top + bus.rel];
  assign bus.top = cur.top;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule
`default_nettype wire

// ---- hw/numeric_format_converter.sv ----
// memory-format to extended-precision converter with register stack and fault pointers
// assumes the host presents operands as little-endian byte images, byte 0 in bits 7:0
`timescale 1ns/100ps
`default_nettype none
module numeric_format_converter (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_store_in,
  input wire fmt_pkg::fmt_e cmd_fmt_in,
  input wire logic cmd_explicit_in,
  input wire logic [2:0] cmd_reg_in,
  input wire logic cmd_pop_in,
  input wire logic [fmt_pkg::ADDR_W-1:0] cmd_instr_addr_in,
  input wire logic [fmt_pkg::ADDR_W-1:0] cmd_operand_addr_in,
  input wire logic [fmt_pkg::EXT_W-1:0] mem_data_in,
  output logic [fmt_pkg::EXT_W-1:0] mem_data_out,
  output logic done_out,
  input wire logic escape_issued_in,
  input wire logic err_clear_in,
  output logic err_out,
  output logic [fmt_pkg::ADDR_W-1:0] instr_ptr_out,
  output logic [fmt_pkg::ADDR_W-1:0] operand_ptr_out,
  output logic [2:0] stack_top_out
);
  import fmt_pkg::*;

  typedef struct packed {
    conv_state_e state;
    logic store;
    logic explicit_sel;
    logic [2:0] reg_idx;
    logic sign;
    logic [63:0] acc;
    logic [BCD_W-1:0] bcd;
    logic [6:0] cnt;
    logic [EXT_W-1:0] out_data;
    logic done;
    logic err_pending;
    logic err;
    logic [ADDR_W-1:0] cur_instr;
    logic [ADDR_W-1:0] cur_operand;
    logic [ADDR_W-1:0] instr_ptr;
    logic [ADDR_W-1:0] operand_ptr;
  } conv_s;

  conv_s cur;
  conv_s next_cur;
  stack_if sbus ();

  ////////////////////////////////////////////////////////////////////////////
  // conversion functions

  // two's complement integer to extended, normalised so the integer bit is set
  function automatic logic [79:0] int_to_ext(input logic [63:0] v);
    logic s;
    logic [63:0] m;
    logic [6:0] lz;
    logic found;
    s = v[63];
    m = s ? (~v + 64'h0000_0000_0000_0001) : v;
    lz = 7'h00;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found && m[i]) begin
        found = 1'b1;
      end else if (!found) begin
        lz = lz + 7'h01;
      end
    end
    if (m == 64'h0000_0000_0000_0000) begin
      return 80'h0;
    end
    return {s, BIAS_EXT + 15'h003f - {8'h00, lz}, m << lz};
  endfunction

  // extended to w-bit two's complement, truncating toward zero
  function automatic logic [63:0] ext_to_int(input logic [79:0] x, input logic [6:0] w,
      output logic ovf);
    logic [14:0] sh;
    logic [63:0] mag;
    logic [63:0] lim;
    logic [63:0] r;
    ovf = 1'b0;
    r = 64'h0000_0000_0000_0000;
    sh = x[78:64] - BIAS_EXT;
    lim = (64'h0000_0000_0000_0001 << (w - 7'h01)) - {63'h0, ~x[SIGN_EXT]};
    if (x[78:64] < BIAS_EXT) begin
      r = 64'h0000_0000_0000_0000;
    end else if (x[78:64] == EXP_EXT_MAX || sh > 15'h003f) begin
      ovf = 1'b1;
    end else begin
      mag = x[63:0] >> (6'h3f - sh[5:0]);
      if (mag > lim) begin
        ovf = 1'b1;
      end else begin
        r = x[SIGN_EXT] ? (~mag + 64'h0000_0000_0000_0001) : mag;
      end
    end
    if (ovf) begin
      r = INT_INDEFINITE >> (7'h40 - w);
    end
    return r;
  endfunction

  // binary real image to extended; subnormal inputs flush to signed zero
  function automatic logic [79:0] real_to_ext(input logic [63:0] d, input logic is_long);
    logic s;
    logic [14:0] e;
    logic [62:0] f;
    logic zero;
    logic special;
    s = is_long ? d[SIGN_LONG] : d[SIGN_SHORT];
    e = is_long ? {4'h0, d[62:52]} : {7'h00, d[30:23]};
    f = is_long ? {d[51:0], 11'h000} : {d[22:0], 40'h00_0000_0000};
    zero = (e == 15'h0000);
    special = is_long ? (e == LONG_EXP_MAX[14:0]) : (e == SHORT_EXP_MAX[14:0]);
    if (zero) begin
      return {s, 79'h0};
    end else if (special) begin
      return {s, EXP_EXT_MAX, 1'b1, f};
    end
    return {s, e - (is_long ? BIAS_LONG : BIAS_SHORT) + BIAS_EXT, 1'b1, f};
  endfunction

  // extended to binary real image; the integer bit is dropped, excess precision truncated
  function automatic logic [63:0] ext_to_real(input logic [79:0] x, input logic is_long,
      output logic ovf);
    logic s;
    logic [16:0] ne;
    logic [16:0] emax;
    logic [51:0] f;
    logic special;
    s = x[SIGN_EXT];
    ovf = 1'b0;
    special = (x[78:64] == EXP_EXT_MAX);
    emax = is_long ? LONG_EXP_MAX : SHORT_EXP_MAX;
    ne = {2'b00, x[78:64]} - {2'b00, BIAS_EXT} + {2'b00, is_long ? BIAS_LONG : BIAS_SHORT};
    f = is_long ? x[62:11] : {29'h0, x[62:40]};
    if (x[78:64] == 15'h0000 || ne[16] || ne == 17'h0_0000) begin
      ne = 17'h0_0000;
      f = 52'h0;
    end else if (special || ne >= emax) begin
      ovf = !special;
      ne = emax;
      f = special ? f : 52'h0;
    end
    if (is_long) begin
      return {s, ne[10:0], f};
    end
    return {32'h0000_0000, s, ne[7:0], f[22:0]};
  endfunction

  // one double-dabble correction: add three to every digit of five or more
  function automatic logic [71:0] dabble_adjust(input logic [71:0] b);
    logic [71:0] r;
    r = b;
    for (int i = 0; i < BCD_DIGITS; i++) begin
      if (r[i*4 +: 4] >= 4'h5) begin
        r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control

  logic accept;
  logic conv_ovf;
  logic int_ovf;
  logic [6:0] int_w;
  logic [63:0] int_val;
  logic [63:0] bcd_mag;
  logic [79:0] load_val;
  logic [79:0] store_val;
  logic [63:0] ld_int;

  assign cmd_ready_out = (cur.state == ST_IDLE);
  assign accept = cmd_valid_in && cmd_ready_out;

  always_comb begin
    int_w = 7'(WIDTH_I64);
    if (cmd_fmt_in == FMT_I16) begin
      int_w = 7'(WIDTH_I16);
    end else if (cmd_fmt_in == FMT_I32) begin
      int_w = 7'(WIDTH_I32);
    end
    // sign extension from the top of the narrow image
    ld_int = mem_data_in[63:0];
    if (cmd_fmt_in == FMT_I16) begin
      ld_int = {{48{mem_data_in[15]}}, mem_data_in[15:0]};
    end else if (cmd_fmt_in == FMT_I32) begin
      ld_int = {{32{mem_data_in[31]}}, mem_data_in[31:0]};
    end
    int_val = ext_to_int(sbus.rd_data, int_w, int_ovf);
    bcd_mag = int_val[63] ? (~int_val + 64'h0000_0000_0000_0001) : int_val;
    load_val = mem_data_in;
    store_val = sbus.rd_data;
    conv_ovf = 1'b0;
    case (cmd_fmt_in)
      FMT_I16, FMT_I32, FMT_I64: begin
        load_val = int_to_ext(ld_int);
        store_val = {16'h0000, int_val & ((64'h0000_0000_0000_0001 << int_w) - 64'h1)};
        if (int_w == 7'(WIDTH_I64)) begin
          store_val = {16'h0000, int_val};
        end
        conv_ovf = int_ovf;
      end
      FMT_R32, FMT_R64: begin
        load_val = real_to_ext(mem_data_in[63:0], cmd_fmt_in == FMT_R64);
        store_val = {16'h0000, ext_to_real(sbus.rd_data, cmd_fmt_in == FMT_R64, conv_ovf)};
      end
      FMT_BCD: begin
        conv_ovf = int_ovf || (bcd_mag >= BCD_LIMIT);
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    // a clear gives way to an error raised in the same cycle
    next_cur.err_pending = cur.err_pending && !err_clear_in;
    sbus.wr_en = 1'b0;
    sbus.push = 1'b0;
    sbus.pop = 1'b0;
    sbus.rel = cmd_explicit_in ? cmd_reg_in : 3'h0;
    sbus.wr_data = load_val;
    case (cur.state)
      ST_IDLE: begin
        if (accept) begin
          next_cur.store = cmd_store_in;
          next_cur.explicit_sel = cmd_explicit_in;
          next_cur.reg_idx = cmd_reg_in;
          next_cur.cur_instr = cmd_instr_addr_in;
          next_cur.cur_operand = cmd_operand_addr_in;
          next_cur.state = ST_DONE;
          if (cmd_store_in) begin
            sbus.pop = cmd_pop_in && !cmd_explicit_in;
            next_cur.out_data = store_val;
            if (conv_ovf) begin
              next_cur.err_pending = 1'b1;
            end
            if (cmd_fmt_in == FMT_BCD) begin
              next_cur.sign = sbus.rd_data[SIGN_EXT];
              next_cur.acc = conv_ovf ? 64'h0000_0000_0000_0000 : bcd_mag;
              next_cur.bcd = '0;
              next_cur.cnt = DABBLE_INIT;
              next_cur.state = ST_BCD_STORE;
            end
          end else if (cmd_fmt_in == FMT_BCD) begin
            next_cur.sign = mem_data_in[SIGN_BCD];
            next_cur.bcd = mem_data_in[BCD_W-1:0];
            next_cur.acc = 64'h0000_0000_0000_0000;
            next_cur.cnt = {1'b0, BCD_STEPS_INIT};
            next_cur.state = ST_BCD_LOAD;
          end else begin
            sbus.wr_en = 1'b1;
            sbus.push = !cmd_explicit_in;
          end
        end
      end
      ST_BCD_LOAD: begin
        // most significant digit first, so the last digit taken is digit zero
        next_cur.acc = (cur.acc << 3) + (cur.acc << 1) + {60'h0, cur.bcd[71:68]};
        next_cur.bcd = cur.bcd << 4;
        next_cur.cnt = cur.cnt - 7'h01;
        if (cur.bcd[71:68] > 4'h9) begin
          next_cur.err_pending = 1'b1;
        end
        if (cur.cnt == 7'h00) begin
          sbus.rel = cur.explicit_sel ? cur.reg_idx : 3'h0;
          sbus.wr_data = int_to_ext(cur.sign ? (~cur.acc + 64'h1) : cur.acc);
          sbus.wr_en = 1'b1;
          sbus.push = !cur.explicit_sel;
          next_cur.acc = cur.acc;
          next_cur.state = ST_DONE;
        end
      end
      ST_BCD_STORE: begin
        // one bit a cycle keeps the adder small at the cost of 64 cycles
        {next_cur.bcd, next_cur.acc} = {dabble_adjust(cur.bcd), cur.acc} << 1;
        next_cur.cnt = cur.cnt - 7'h01;
        if (cur.cnt == 7'h00) begin
          next_cur.bcd = cur.bcd;
          next_cur.acc = cur.acc;
          next_cur.out_data = {cur.sign, 7'h00, cur.bcd};
          next_cur.state = ST_DONE;
        end
      end
      default: begin
        next_cur.done = 1'b1;
        next_cur.state = ST_IDLE;
      end
    endcase
    // capture the failing addresses when an error is newly raised
    if (next_cur.err_pending && !(cur.err_pending && !err_clear_in)) begin
      next_cur.instr_ptr = next_cur.cur_instr;
      next_cur.operand_ptr = next_cur.cur_operand;
    end
    next_cur.err = next_cur.err_pending && escape_issued_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register and stack

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  reg_stack u_stack (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bus(sbus.store)
  );

  assign mem_data_out = cur.out_data;
  assign done_out = cur.done;
  assign err_out = cur.err;
  assign instr_ptr_out = cur.instr_ptr;
  assign operand_ptr_out = cur.operand_ptr;
  assign stack_top_out = sbus.top;
endmodule
`default_nettype wire

// ---- test/host_memory.sv ----
// host side model: byte memory through which the host moves operand images
// assumes the bench calls put and fetch between commands, never during one
`timescale 1ns/100ps
`default_nettype none
module host_memory;
  logic [7:0] mem [0:255];
  ////////////////////////////////////////////////////////////////////////////
  // least significant byte lands at the lowest address
  task automatic put(input int adr, input logic [79:0] v);
    for (int i = 0; i < 10; i++) mem[(adr + i) % 256] = v[i*8 +: 8];
  endtask
  // reads start at the lowest address; callers keep adr even for speed
  function automatic logic [79:0] fetch(input int adr, input int n);
    fetch = '0;
    for (int i = 0; i < n; i++) fetch[i*8 +: 8] = mem[(adr + i) % 256];
  endfunction
endmodule
`default_nettype wire

// ---- test/numeric_format_converter_properties.sv ----
// timing properties of the format converter, seen from its top ports only
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module numeric_format_converter_properties
  import fmt_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic cmd_store_in,
  input wire fmt_pkg::fmt_e cmd_fmt_in,
  input wire logic cmd_explicit_in,
  input wire logic cmd_pop_in,
  input wire logic done_out,
  input wire logic escape_issued_in,
  input wire logic err_out,
  input wire logic [2:0] stack_top_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic take;
  assign take = cmd_valid_in && cmd_ready_out;
  ////////////////////////////////////////////////////////////////////////////
  AST_FAST_DONE: assert property (take && cmd_fmt_in != FMT_BCD |=> !cmd_ready_out ##1 done_out)
    else $error("command did not finish two cycles after it was taken");
  AST_BCD_LOAD: assert property (take && cmd_fmt_in == FMT_BCD && !cmd_store_in |=>
    !cmd_ready_out ##[1:25] done_out)
    else $error("decimal load did not finish in time");
  AST_BCD_STORE: assert property (take && cmd_fmt_in == FMT_BCD && cmd_store_in |=>
    !cmd_ready_out ##[1:80] done_out)
    else $error("decimal store did not finish in time");
  AST_PULSE: assert property (done_out |-> cmd_ready_out ##1 !done_out)
    else $error("done is not a single pulse with ready");
  AST_PUSH: assert property (take && !cmd_store_in && !cmd_explicit_in &&
    cmd_fmt_in != FMT_BCD |=> stack_top_out == $past(stack_top_out) - 3'h1)
    else $error("implicit load did not push");
  AST_BCD_PUSH: assert property (take && !cmd_store_in && !cmd_explicit_in &&
    cmd_fmt_in == FMT_BCD |=> ##19 stack_top_out == $past(stack_top_out, 20) - 3'h1)
    else $error("implicit decimal load did not push when it wrote");
  AST_POP: assert property (take && cmd_store_in && !cmd_explicit_in &&
    cmd_pop_in |=> stack_top_out == $past(stack_top_out) + 3'h1)
    else $error("store with pop did not pop");
  AST_HOLD: assert property (take && cmd_fmt_in != FMT_BCD &&
    (cmd_explicit_in || cmd_store_in && !cmd_pop_in) |=> $stable(stack_top_out))
    else $error("top moved on an access that must leave it");
  AST_TOP_CAUSE: assert property ($changed(stack_top_out) |-> $past(take) || !$past(cmd_ready_out))
    else $error("top moved without a command");
  AST_ERR_GATE: assert property (err_out |-> $past(escape_issued_in))
    else $error("error shown before the escape opcode was issued");
  ////////////////////////////////////////////////////////////////////////////
  cover property (take && !cmd_store_in);
  cover property (take && cmd_store_in && cmd_fmt_in == FMT_BCD);
  cover property (err_out);
endmodule
bind numeric_format_converter numeric_format_converter_properties props_u (.sys_clk_in,
  .rst_n_in, .cmd_valid_in, .cmd_ready_out, .cmd_store_in, .cmd_fmt_in, .cmd_explicit_in,
  .cmd_pop_in, .done_out, .escape_issued_in, .err_out, .stack_top_out);
`default_nettype wire

// ---- test/numeric_format_converter_test.sv ----
// bench: random and corner round trips of every format, stack depth, error report
// assumes fmt_pkg, stack_if, reg_stack, the converter and host_memory compiled first
`timescale 1ns/100ps
`default_nettype none
module numeric_format_converter_test;
  import fmt_pkg::*;
  localparam logic [79:0] PAD = {1'b0, 7'h7f, 72'h0};
  logic sys_clk_in = '0;
  logic rst_n_in = '0;
  logic cmd_valid_in = '0;
  logic cmd_store_in = '0;
  logic cmd_explicit_in = '0;
  logic cmd_pop_in = '0;
  logic escape_issued_in = '0;
  logic err_clear_in = '0;
  fmt_e cmd_fmt_in = FMT_I16;
  logic [2:0] cmd_reg_in = '0;
  logic [31:0] cmd_instr_addr_in = '0;
  logic [31:0] cmd_operand_addr_in = '0;
  logic [79:0] mem_data_in = '0;
  logic [79:0] mem_data_out;
  logic cmd_ready_out;
  logic done_out;
  logic err_out;
  logic [31:0] instr_ptr_out;
  logic [31:0] operand_ptr_out;
  logic [2:0] stack_top_out;
  int mismatches = 0;
  int total_checks = 0;
  logic [79:0] v [0:7];
  fmt_e cf [0:5] = '{FMT_I16, FMT_I16, FMT_I16, FMT_I64, FMT_R32, FMT_BCD};
  logic [79:0] cv [0:5] = '{80'h8000, 80'hffff, 80'h0000, 80'h8000_0000_0000_0000,
    80'h3f80_0000, 80'h8099_9999_9999_9999_9999};
  host_memory host_u ();
  numeric_format_converter dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_store_in(cmd_store_in), .cmd_fmt_in(cmd_fmt_in),
    .cmd_explicit_in(cmd_explicit_in), .cmd_reg_in(cmd_reg_in), .cmd_pop_in(cmd_pop_in),
    .cmd_instr_addr_in(cmd_instr_addr_in), .cmd_operand_addr_in(cmd_operand_addr_in),
    .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .done_out(done_out),
    .escape_issued_in(escape_issued_in), .err_clear_in(err_clear_in), .err_out(err_out),
    .instr_ptr_out(instr_ptr_out), .operand_ptr_out(operand_ptr_out),
    .stack_top_out(stack_top_out));
  initial forever #4 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int nb(input fmt_e f);
    case (f)
      FMT_I16: return 2;
      FMT_I32, FMT_R32: return 4;
      FMT_I64, FMT_R64: return 8;
      default: return 10;
    endcase
  endfunction
  function automatic logic [79:0] to_ext(input fmt_e f, input logic [79:0] m);
    logic signed [63:0] s;
    logic [63:0] u;
    int p;
    case (f)
      FMT_I16: s = $signed(m[15:0]);
      FMT_I32: s = $signed(m[31:0]);
      FMT_I64: s = m[63:0];
      FMT_R32: return {m[31], m[30:23] + BIAS_EXT - BIAS_SHORT, 1'b1, m[22:0], 40'h0};
      FMT_R64: return {m[63], m[62:52] + BIAS_EXT - BIAS_LONG, 1'b1, m[51:0], 11'h0};
      FMT_BCD: begin
        s = 0;
        for (int i = 17; i >= 0; i--) s = s * 10 + m[i*4 +: 4];
        if (m[79]) s = -s;
      end
      default: return m;
    endcase
    u = s[63] ? -s : s;
    if (u == 0) return '0;
    p = 63;
    while (!u[p]) p--;
    return {s[63], 15'(p) + BIAS_EXT, u << (63 - p)};
  endfunction
  // exponent kept away from the zero and infinity codes: only normal values
  function automatic logic [79:0] rand_img(input fmt_e f);
    logic [79:0] r;
    r = 80'({$urandom, $urandom, $urandom});
    case (f)
      FMT_I16: r[79:16] = '0;
      FMT_I32, FMT_R32: r[79:32] = '0;
      FMT_I64, FMT_R64: r[79:64] = '0;
      FMT_BCD: for (int i = 0; i < 18; i++) r[i*4 +: 4] = 4'($urandom % 10);
      default: ;
    endcase
    if (f == FMT_R32 && r[30:23] inside {8'h00, 8'hff}) r[30:23] = 8'h40;
    if (f == FMT_R64 && r[62:52] inside {11'h000, 11'h7ff}) r[62:52] = 11'h400;
    return r;
  endfunction
  task automatic run(input logic st, input fmt_e f, input logic ex, input logic [2:0] r,
      input logic pp, input int a);
    int n;
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_store_in <= st;
    cmd_fmt_in <= f;
    cmd_explicit_in <= ex;
    cmd_reg_in <= r;
    cmd_pop_in <= pp;
    cmd_operand_addr_in <= 32'(a);
    cmd_instr_addr_in <= 32'(a) + 32'h0000_0100;
    mem_data_in <= host_u.fetch(a, nb(f));
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (cmd_ready_out !== 1'b1 && n < 200);
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (done_out !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      complete_run();
    end
    if (st) host_u.put(a, mem_data_out);
  endtask
  task automatic round(input fmt_e f, input logic [79:0] m, input int a);
    host_u.put(a, m);
    run(1'b0, f, 1'b0, 3'h0, 1'b0, a);
    run(1'b1, FMT_EXT, 1'b0, 3'h0, 1'b1, a);
    check(host_u.fetch(a, 10), to_ext(f, m));
    host_u.put(a, m);
    run(1'b0, f, 1'b0, 3'h0, 1'b0, a);
    run(1'b1, f, 1'b0, 3'h0, 1'b1, a);
    check(host_u.fetch(a, nb(f)), f == FMT_BCD ? m & ~PAD : m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hbd1d));
    repeat (8) @(posedge sys_clk_in);
    check(stack_top_out, 80'h0);
    rst_n_in <= 1'b1;
    foreach (cv[i]) round(cf[i], cv[i], 2 * i);
    for (int k = 0; k < 8; k++) begin
      for (int f = 0; f < 6; f++) round(fmt_e'(f), rand_img(fmt_e'(f)), 2 * k);
    end
    // eight pushes wrap the top back to where it started
    for (int i = 0; i < 8; i++) begin
      v[i] = rand_img(FMT_EXT);
      host_u.put(16 * i, v[i]);
      run(1'b0, FMT_EXT, 1'b0, 3'h0, 1'b0, 16 * i);
    end
    check(stack_top_out, 80'h0);
    run(1'b1, FMT_EXT, 1'b1, 3'h7, 1'b0, 200);
    check(host_u.fetch(200, 10), v[0]);
    v[5] = rand_img(FMT_EXT);
    host_u.put(200, v[5]);
    run(1'b0, FMT_EXT, 1'b1, 3'h2, 1'b0, 200);
    for (int i = 7; i >= 0; i--) begin
      run(1'b1, FMT_EXT, 1'b0, 3'h0, 1'b1, 16 * i);
      check(host_u.fetch(16 * i, 10), v[i]);
    end
    // 16-bit overflow stores the indefinite value and raises a held error
    host_u.put(64, 80'h0001_0000);
    run(1'b0, FMT_I32, 1'b0, 3'h0, 1'b0, 64);
    run(1'b1, FMT_I16, 1'b0, 3'h0, 1'b1, 64);
    check(host_u.fetch(64, 2), 80'h8000);
    check(err_out, 80'h0);
    check(instr_ptr_out, 80'h0140);
    check(operand_ptr_out, 80'h0040);
    @(posedge sys_clk_in);
    escape_issued_in <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check(err_out, 80'h1);
    @(posedge sys_clk_in);
    err_clear_in <= 1'b1;
    @(posedge sys_clk_in);
    err_clear_in <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check(err_out, 80'h0);
    // digit one holds a code above nine: a load error that records its addresses
    host_u.put(96, 80'h00a0);
    run(1'b0, FMT_BCD, 1'b0, 3'h0, 1'b0, 96);
    check(err_out, 80'h1);
    check(instr_ptr_out, 80'h0160);
    check(operand_ptr_out, 80'h0060);
    complete_run();
  end
endmodule
`default_nettype wire
